// file: stcr_host.sv
// Purpose: Host serial master model for the register bank bench
// Assumes: 80 ns link clock that stands still between frames
// Notes:   A released data line shows the inverse of its last bit
`default_nettype none

module stcr_host (
  // Serial pins
  output var  logic spi_sclk,
  output var  logic spi_cs_n,
  output var  logic spi_mosi,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // ==========================================================
  // One frame; the answer of the previous frame comes back
  task automatic xfer(input logic wr, input logic [5:0] a,
    input logic [15:0] d, input logic bad, output logic [23:0] r);
    logic [23:0] w;
    w = {wr, a, ~(^{wr, a, d}) ^ bad, d};
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_mosi = w[i];
      #40;
      r[i] = spi_miso;
      spi_sclk = 1'b1;
      #40;
      spi_sclk = 1'b0;
    end
    #40;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    // Gap covers core action and answer update
    #1000;
  endtask
endmodule

`default_nettype wire

// file: stcr_link.sv
// Purpose: Serial slave front end on the link clock
// Assumes: Host shifts MSB first, samples the answer on rising clock edges
// Notes:   Answer word must stay stable while chip select is low
`default_nettype none

module stcr_link (
  // Reset
  input  wire logic                         resetn,
  // Serial pins
  input  wire logic                         spi_sclk,
  input  wire logic                         spi_cs_n,
  input  wire logic                         spi_mosi,
  output var  logic                         spi_miso,
  output var  logic                         spi_miso_oe,
  // Core side
  input  wire logic [stcr_pkg::FRAME_W-1:0] resp_i,
  output var  logic [stcr_pkg::FRAME_W-1:0] word_o,
  output var  logic                         word_tog_o,
  output var  logic                         over_tog_o
);
  import stcr_pkg::*;

  // ==========================================================================
  // State: frame part dies with chip select, hand-over part survives frames
  typedef struct packed {
    logic [CNT_W-1:0]   cnt;
    logic [FRAME_W-2:0] shift;
  } stcr_frame_t;

  typedef struct packed {
    logic [FRAME_W-1:0] word;
    logic               word_tog;
    logic               over_tog;
  } stcr_hand_t;

  stcr_frame_t fq;
  stcr_frame_t fd;
  stcr_hand_t  hq;
  stcr_hand_t  hd;
  logic        frame_rst;

  // Clock stands still outside frames, so chip select ends the frame
  assign frame_rst = spi_cs_n | ~resetn;

  always_comb begin
    fd       = fq;
    hd       = hq;
    fd.shift = {fq.shift[FRAME_W-3:0], spi_mosi};
    if (fq.cnt != FRAME_CNT) begin
      fd.cnt = fq.cnt + 1'b1;
    end
    // Word crosses by toggle; core reads word only after the toggle
    if (fq.cnt == LAST_BIT) begin
      hd.word     = {fq.shift, spi_mosi};
      hd.word_tog = ~hq.word_tog;
    end
    if (fq.cnt == FRAME_CNT) begin
      hd.over_tog = ~hq.over_tog;
    end
  end

  always_ff @(posedge spi_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      fq <= '0;
    end else begin
      fq <= fd;
    end
  end

  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      hq <= '0;
    end else begin
      hq <= hd;
    end
  end

  // ==========================================================================
  // Answer: bit k of the frame stands from edge k to edge k+1
  always_comb begin
    spi_miso_oe = ~spi_cs_n;
    spi_miso    = 1'b0;
    if (fq.cnt != FRAME_CNT) begin
      spi_miso = resp_i[LAST_BIT - fq.cnt];
    end
  end

  assign word_o     = hq.word;
  assign word_tog_o = hq.word_tog;
  assign over_tog_o = hq.over_tog;

endmodule

`default_nettype wire

// file: stcr_pkg.sv
// Purpose: Shared constants and types of the sensor transceiver register bank
// Assumes: 10 MHz core clock, 24-bit serial frames, 6-bit register index
// Notes:   Register map offsets below are register indexes carried in the frame; field offsets are bit positions
`default_nettype none

package stcr_pkg;

  // ==========================================================================
  // Serial frame layout
  localparam int FRAME_W   = 24;
  localparam int CNT_W     = 5;
  localparam int F_WR      = 23;
  localparam int F_ADDR_HI = 22;
  localparam int F_ADDR_LO = 17;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 16;
  localparam int STAT_W    = 8;
  localparam logic [CNT_W-1:0] LAST_BIT  = 5'h17;
  localparam logic [CNT_W-1:0] FRAME_CNT = 5'h18;

  // Status byte returned in every answer
  localparam int ST_GBIT = 7;
  localparam int ST_SFLT = 6;
  localparam int ST_LOCK = 5;
  localparam int ST_ANY  = 4;

  // ==========================================================================
  // Register map
  typedef logic [ADDR_W-1:0] stcr_addr_t;
  localparam stcr_addr_t A_GCR    = 6'h01;
  localparam stcr_addr_t A_CHC    = 6'h02;
  localparam stcr_addr_t A_NOP    = 6'h03;
  localparam stcr_addr_t A_SR1    = 6'h04;
  localparam stcr_addr_t A_SR2    = 6'h05;
  localparam stcr_addr_t A_SR3    = 6'h06;
  localparam stcr_addr_t A_UDBCR  = 6'h07;
  localparam stcr_addr_t A_DIRCMD = 6'h3f;
  localparam stcr_addr_t A_UDB_FIRST [2] = '{6'h08, 6'h0c};
  localparam stcr_addr_t A_UDB_LAST  [2] = '{6'h0b, 6'h0f};
  localparam logic [DATA_W-1:0] CMD_EOP = 16'h00e0;

  localparam logic [DATA_W-1:0] GCR_RST   = 16'h8000;
  localparam logic [DATA_W-1:0] CHC_RST   = 16'h0442;
  localparam logic [DATA_W-1:0] GCR_WMASK = 16'hffdf;
  localparam logic [DATA_W-1:0] CHC_WMASK = 16'h077b;
  localparam logic [DATA_W-1:0] SR1_LATCH = 16'hd5ff;

  // General configuration fields, per channel index 0 = channel 1
  localparam int GCR_MUXOFF = 14;
  localparam int GCR_CLK_LO = 3;
  localparam int GCR_SIDG   = 2;
  localparam int GCR_CRC    = 1;
  localparam int GCR_VSEL   = 0;
  localparam int GCR_EXT     [2] = '{9, 13};
  localparam int GCR_TRIG_LO [2] = '{7, 11};
  localparam int GCR_METH    [2] = '{6, 10};

  // Channel control fields
  localparam int CHC_REG_EN = 10;
  localparam int CHC_SREQ_LO [2] = '{3, 8};
  localparam int CHC_PERMIT  [2] = '{1, 6};
  localparam int CHC_ON      [2] = '{0, 5};

  // First status register fields
  localparam int SR1_DONE = 15;
  localparam int SR1_ABT  = 14;
  localparam int SR1_RUN  = 13;
  localparam int SR1_SFLT = 12;
  localparam int SR1_OTP  = 11;
  localparam int SR1_UV   = 10;
  localparam int SR1_OV   = 9;
  localparam int SR1_UVL  = 8;
  localparam int SR1_TOUT   [2] = '{3, 7};
  localparam int SR1_BFLT   [2] = '{2, 6};
  localparam int SR1_LATE   [2] = '{1, 5};
  localparam int SR1_LOWAMP [2] = '{0, 4};

  // Field codes
  localparam logic [1:0] TRIG_SERIAL = 2'h1;
  localparam logic [1:0] TRIG_TIMER  = 2'h2;
  localparam logic [1:0] SREQ_SHORT  = 2'h1;
  localparam logic [1:0] SREQ_LONG   = 2'h2;
  localparam logic [1:0] CLK_1MHZ    = 2'h1;
  localparam logic [1:0] CLK_4MHZ    = 2'h2;
  localparam logic [4:0] PAY_A       = 5'h0a;
  localparam logic [4:0] PAY_B       = 5'h10;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int PAR_CHECK_US   = 150;
  localparam int SYNC_TOUT_US   = 100;
  localparam int PAR_CHECK_CYC  = PAR_CHECK_US * 1000 / CLK_PERIOD_NS;
  localparam int SYNC_TOUT_CYC  =
    (SYNC_TOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PCHK_W = 11;
  localparam int TOUT_W = 11;
  localparam logic [PCHK_W-1:0] PCHK_LAST  = PCHK_W'(PAR_CHECK_CYC - 1);
  localparam logic [TOUT_W-1:0] TOUT_LIMIT = TOUT_W'(SYNC_TOUT_CYC);

  // Core synchroniser idle value: chip select high, toggles and pins low
  localparam logic [4:0] SYNC_IDLE = 5'h01;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       power_on;
    logic       sync_permit;
    logic [1:0] trigger_source;
    logic       buffer_length_sel;
    logic       pulse_method;
  } stcr_chan_cfg_t;

  typedef struct packed {
    stcr_chan_cfg_t [1:0] ch;
    logic                 addr_multiplex_off;
    logic                 ext_clk_1mhz;
    logic                 ext_clk_4mhz;
    logic                 sensor_id_gbit_active;
    logic                 check_bits_source;
    logic                 regulator_level_select;
    logic                 regulator_enable;
  } stcr_cfg_t;

  typedef struct packed {
    logic req;
    logic long_pulse;
  } stcr_sync_t;

  typedef struct packed {
    logic       coupling_test_done;
    logic       coupling_test_aborted;
    logic       coupling_test_active;
    logic       trim_check_error;
    logic       regulator_undervolt;
    logic       regulator_overvolt;
    logic       regulator_deep_undervolt_off;
    logic       sensor_read_seq_err;
    logic [1:0] ch_sync_late;
    logic [1:0] ch_sync_low_amplitude;
    logic [1:0] ch_buffer_pending;
    logic [1:0] ch_sync_mode;
    logic [4:0] payload_len;
  } stcr_diag_t;

endpackage

`default_nettype wire

// file: stcr_regs.sv
// Purpose: Configuration and first status registers of a two-channel
//          sensor transceiver, reached through a four-wire serial port
// Assumes: 10 MHz core clock; link clock from the host; frame is
//          {wr, addr[5:0], odd parity, data[15:0]}, 24 bits, MSB first
// Notes:   Answer of a frame is shifted out during the next frame
//
// How it works
// - Locked config writes ignored after end command
// - Odd parity safety register, periodic check sets fault
// - Bit 14 turns address multiplexing off
// - Per-channel trigger source: pin, serial, timer
// - Buffer length select, forced by timer source
// - Pulse method only honoured in buffer mode
// - Reference clock field: none, 1 MHz, 4 MHz
// - Sensor id enable only for 10/16-bit payloads
// - Check bits forwarded or computed locally
// - Bit 0 selects regulator output level
// - Regulator enable bit, resets to one
// - Serial sync request codes: none, short, long
// - Serial request acts once, not when off
// - Buffer mode makes short and long equal
// - Sync permit gated by synchronous mode
// - Channel power bits switch channels on/off
// - No-operation write changes nothing, returns status
// - Coupling test done/abort latched, running live
// - Serial fault latched on frame errors
// - Undervolt latched, overvolt live, deep flag cleared
// - Sync pin held past timeout sets flag
// - Buffer write while pending sets fault
// - Host masters the four-wire serial port
`default_nettype none

module stcr_regs (
  // Core clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Serial port
  input  wire logic                       spi_sclk,
  input  wire logic                       spi_cs_n,
  input  wire logic                       spi_mosi,
  output var  logic                       spi_miso,
  output var  logic                       spi_miso_oe,
  // Sync trigger pins
  input  wire logic [1:0]                 sync_pin,
  // Analog and channel side
  input  wire stcr_pkg::stcr_diag_t       diag_i,
  output var  stcr_pkg::stcr_cfg_t        cfg_o,
  output var  stcr_pkg::stcr_sync_t [1:0] sync_o,
  // Global state
  output var  logic                       global_fault_o,
  output var  logic                       config_locked_o
);
  import stcr_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [4:0]             s1;
    logic [4:0]             s2;
    logic [4:0]             s3;
    logic [DATA_W-1:0]      gcr;
    logic [DATA_W-1:0]      chc;
    logic                   locked;
    logic                   gbit;
    logic [DATA_W-1:0]      sr1;
    logic                   got_word;
    logic [PCHK_W-1:0]      pchk;
    logic [1:0][TOUT_W-1:0] tout;
    stcr_sync_t [1:0]       sync;
    logic [FRAME_W-1:0]     resp;
  } stcr_core_t;

  localparam stcr_core_t CORE_RST = '{
    s1:      SYNC_IDLE,
    s2:      SYNC_IDLE,
    s3:      SYNC_IDLE,
    gcr:     GCR_RST,
    chc:     CHC_RST,
    default: '0
  };

  stcr_core_t         q;
  stcr_core_t         d;
  logic [FRAME_W-1:0] word;
  logic               word_tog;
  logic               over_tog;

  // ==========================================================================
  // Link front end
  stcr_link u_link (
    .resetn      (resetn),
    .spi_sclk    (spi_sclk),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .resp_i      (q.resp),
    .word_o      (word),
    .word_tog_o  (word_tog),
    .over_tog_o  (over_tog)
  );

  // ==========================================================================
  // Crossing events, read from the second stage onward only
  logic word_evt;
  logic over_evt;
  logic cs_fall;
  logic cs_rise;

  assign word_evt = q.s2[1] ^ q.s3[1];
  assign over_evt = q.s2[2] ^ q.s3[2];
  assign cs_fall  = q.s3[0] & ~q.s2[0];
  assign cs_rise  = ~q.s3[0] & q.s2[0];

  // Frame fields; word is stable for many cycles after its toggle
  logic              wr;
  stcr_addr_t        addr;
  logic [DATA_W-1:0] data;
  logic              par_ok;

  assign wr     = word[F_WR];
  assign addr   = word[F_ADDR_HI:F_ADDR_LO];
  assign data   = word[DATA_W-1:0];
  assign par_ok = ^word;

  // ==========================================================================
  // Decode and outputs
  logic [1:0]        ext_eff;
  logic [DATA_W-1:0] rt;
  logic [DATA_W-1:0] rd_val;
  logic [STAT_W-1:0] stat;
  logic              addr_ok;

  always_comb begin
    cfg_o = '0;
    for (int i = 0; i < 2; i++) begin
      ext_eff[i] = q.gcr[GCR_EXT[i]] |
                   (q.gcr[GCR_TRIG_LO[i] +: 2] == TRIG_TIMER);
      cfg_o.ch[i].power_on          = q.chc[CHC_ON[i]];
      cfg_o.ch[i].sync_permit       = q.chc[CHC_PERMIT[i]] &
                                      diag_i.ch_sync_mode[i];
      cfg_o.ch[i].trigger_source    = q.gcr[GCR_TRIG_LO[i] +: 2];
      cfg_o.ch[i].buffer_length_sel = ext_eff[i];
      cfg_o.ch[i].pulse_method      = ext_eff[i] &
                                      q.gcr[GCR_METH[i]];
    end
    cfg_o.addr_multiplex_off     = q.gcr[GCR_MUXOFF];
    cfg_o.ext_clk_1mhz = q.gcr[GCR_CLK_LO +: 2] == CLK_1MHZ;
    cfg_o.ext_clk_4mhz = q.gcr[GCR_CLK_LO +: 2] == CLK_4MHZ;
    cfg_o.sensor_id_gbit_active  = q.gcr[GCR_SIDG] &&
      (diag_i.payload_len == PAY_A || diag_i.payload_len == PAY_B);
    cfg_o.check_bits_source      = q.gcr[GCR_CRC];
    cfg_o.regulator_level_select = q.gcr[GCR_VSEL];
    cfg_o.regulator_enable       = q.chc[CHC_REG_EN];

    // Live bits of the first status register
    rt          = '0;
    rt[SR1_RUN] = diag_i.coupling_test_active;
    rt[SR1_OTP] = diag_i.trim_check_error;
    rt[SR1_OV]  = diag_i.regulator_overvolt;

    stat          = '0;
    stat[ST_GBIT] = q.gbit;
    stat[ST_SFLT] = q.sr1[SR1_SFLT];
    stat[ST_LOCK] = q.locked;
    stat[ST_ANY]  = |q.sr1;

    // Out-of-block registers are valid and read as zero; reserved indexes are frame errors
    addr_ok = (addr inside {A_GCR, A_CHC, A_NOP, A_SR1, A_SR2, A_SR3,
                            A_UDBCR, A_DIRCMD}) ||
              (addr >= A_UDB_FIRST[0] && addr <= A_UDB_LAST[1]);

    rd_val = '0;
    if (!wr) begin
      case (addr)
        A_GCR:   rd_val = q.gcr;
        A_CHC:   rd_val = q.chc;
        A_SR1:   rd_val = q.sr1 | rt;
        default: rd_val = '0;
      endcase
    end
  end

  assign sync_o          = q.sync;
  assign global_fault_o  = q.gbit;
  assign config_locked_o = q.locked;

  // ==========================================================================
  // Next state
  logic [DATA_W-1:0] set;
  logic [DATA_W-1:0] clr;

  always_comb begin
    d      = q;
    set    = '0;
    clr    = '0;
    d.s1   = {sync_pin, over_tog, word_tog, spi_cs_n};
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.sync = '0;

    // Periodic recheck of the safety register
    if (q.pchk == PCHK_LAST) begin
      d.pchk = '0;
      d.gbit = ~^q.gcr;
    end else begin
      d.pchk = q.pchk + 1'b1;
    end

    // Analog events
    set[SR1_DONE] = diag_i.coupling_test_done;
    set[SR1_ABT]  = diag_i.coupling_test_aborted;
    set[SR1_UV]   = diag_i.regulator_undervolt;
    set[SR1_UVL]  = diag_i.regulator_deep_undervolt_off;
    set[SR1_SFLT] = diag_i.sensor_read_seq_err | over_evt |
                    (cs_rise & ~(q.got_word | word_evt));

    for (int i = 0; i < 2; i++) begin
      set[SR1_LATE[i]]   = diag_i.ch_sync_late[i];
      set[SR1_LOWAMP[i]] = diag_i.ch_sync_low_amplitude[i];
      // Pin-driven source only: codes other than serial and timer
      if (q.s2[3 + i] && q.chc[CHC_ON[i]] &&
          q.gcr[GCR_TRIG_LO[i] +: 2] != TRIG_SERIAL &&
          q.gcr[GCR_TRIG_LO[i] +: 2] != TRIG_TIMER) begin
        if (q.tout[i] != TOUT_LIMIT) begin
          d.tout[i] = q.tout[i] + 1'b1;
        end
      end else begin
        d.tout[i] = '0;
      end
      set[SR1_TOUT[i]] = (q.tout[i] != TOUT_LIMIT) &&
                         (d.tout[i] == TOUT_LIMIT);
    end

    // Frame bookkeeping
    if (cs_fall) begin
      d.got_word = 1'b0;
    end

    if (word_evt) begin
      d.got_word = 1'b1;
      d.resp     = {stat, rd_val};
      if (!par_ok || !addr_ok) begin
        // Frame discarded, nothing written or cleared
        set[SR1_SFLT] = 1'b1;
      end else if (wr) begin
        case (addr)
          A_GCR: begin
            if (!q.locked) begin
              d.gcr = data & GCR_WMASK;
            end
          end
          A_CHC: begin
            d.chc = data & CHC_WMASK;
            if (!data[CHC_REG_EN]) begin
              clr[SR1_UVL] = 1'b1;
            end
            for (int i = 0; i < 2; i++) begin
              // Evaluated only on this write, never again
              if ((data[CHC_SREQ_LO[i] +: 2] == SREQ_SHORT ||
                   data[CHC_SREQ_LO[i] +: 2] == SREQ_LONG) &&
                  data[CHC_ON[i]] && data[CHC_PERMIT[i]] &&
                  diag_i.ch_sync_mode[i] &&
                  q.gcr[GCR_TRIG_LO[i] +: 2] == TRIG_SERIAL) begin
                d.sync[i].req        = 1'b1;
                d.sync[i].long_pulse =
                  (data[CHC_SREQ_LO[i] +: 2] == SREQ_LONG) &&
                  !ext_eff[i];
              end
            end
          end
          A_DIRCMD: begin
            if (data == CMD_EOP) begin
              d.locked = 1'b1;
            end
          end
          default: begin
            // No-operation and out-of-block registers keep all state
          end
        endcase
        for (int i = 0; i < 2; i++) begin
          if (addr >= A_UDB_FIRST[i] && addr <= A_UDB_LAST[i] &&
              diag_i.ch_buffer_pending[i]) begin
            set[SR1_BFLT[i]] = 1'b1;
          end
        end
      end else if (addr == A_SR1) begin
        clr = SR1_LATCH;
      end
    end

    // New events beat a clear in the same cycle
    d.sr1 = ((q.sr1 & ~clr) | set) & SR1_LATCH;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_good_word;
    word_evt && par_ok && addr_ok;
  endsequence

  sequence s_gcr_write;
    s_good_word ##0 (wr && addr == A_GCR);
  endsequence

  property p_lock_holds;
    q.locked |=> $stable(q.gcr) && q.locked;
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("locked configuration changed");

  property p_gcr_open;
    s_gcr_write ##0 !q.locked |=> q.gcr == ($past(data) & GCR_WMASK);
  endproperty
  a_gcr_open: assert property (p_gcr_open)
    else $error("open configuration write lost");

  property p_parity_check;
    q.pchk == PCHK_LAST |=> q.gbit == ~^$past(q.gcr);
  endproperty
  a_parity_check: assert property (p_parity_check)
    else $error("safety parity check wrong");

  property p_nop;
    s_good_word ##0 (wr && addr == A_NOP) |=> $stable(q.gcr) &&
      $stable(q.chc) && $stable(q.locked) &&
      q.resp == {$past(stat), 16'h0000};
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-operation access altered state");

  property p_bad_frame;
    word_evt && (!par_ok || !addr_ok) |=> q.sr1[SR1_SFLT] &&
      $stable(q.gcr) && $stable(q.chc);
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("bad frame not flagged");

  property p_set_wins;
    diag_i.coupling_test_done |=> q.sr1[SR1_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("coupling test event lost");

  property p_read_clear;
    s_good_word ##0 (!wr && addr == A_SR1 && !diag_i.coupling_test_done)
      |=> !q.sr1[SR1_DONE] ##1 q.resp[SR1_DONE] == $past(q.sr1[SR1_DONE], 2);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear");

  property p_uvl_clear;
    s_good_word ##0 (wr && addr == A_CHC && !data[CHC_REG_EN] &&
      !diag_i.regulator_deep_undervolt_off) |=> !q.sr1[SR1_UVL];
  endproperty
  a_uvl_clear: assert property (p_uvl_clear)
    else $error("deep undervolt flag not cleared");

  for (genvar g = 0; g < 2; g++) begin : g_chk
    property p_pulse_once;
      sync_o[g].req |-> cfg_o.ch[g].power_on ##1 !sync_o[g].req;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
      else $error("serial sync request repeated");

    property p_buf_short;
      sync_o[g].req && cfg_o.ch[g].buffer_length_sel |->
        !sync_o[g].long_pulse;
    endproperty
    a_buf_short: assert property (p_buf_short)
      else $error("buffer mode pulse not length-neutral");

    property p_timer_forces;
      cfg_o.ch[g].trigger_source == TRIG_TIMER |->
        cfg_o.ch[g].buffer_length_sel &&
        cfg_o.ch[g].pulse_method == q.gcr[GCR_METH[g]];
    endproperty
    a_timer_forces: assert property (p_timer_forces)
      else $error("timer source did not force buffer mode");

    property p_tout;
      $rose(q.tout[g] == TOUT_LIMIT) |-> q.sr1[SR1_TOUT[g]];
    endproperty
    a_tout: assert property (p_tout)
      else $error("sync pin timeout not flagged");
  end

endmodule

`default_nettype wire

// file: stcr_regs_tb.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Host model masters the serial port
// Notes:   Answers are seen one frame late
`default_nettype none

module stcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import stcr_pkg::*;
  logic             clk, resetn, sclk, cs_n, mosi, miso, oe, gf, lk;
  logic             lng;
  logic [1:0]       pin;
  stcr_diag_t       diag;
  stcr_cfg_t        cfg;
  stcr_sync_t [1:0] sy;
  logic [23:0]      r;
  int               n_errors, tests_run, cyc, npul;
  stcr_regs DUT (.clk(clk), .resetn(resetn), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(oe), .sync_pin(pin), .diag_i(diag), .cfg_o(cfg),
    .sync_o(sy), .global_fault_o(gf), .config_locked_o(lk));
  stcr_host host (.spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // Pulse monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sy[0].req === 1'b1) begin
      npul <= npul + 1;
      lng <= sy[0].long_pulse;
    end
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  task automatic x(input logic w, input logic [5:0] a,
    input logic [15:0] d, input logic b);
    host.xfer(w, a, d, b, r);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {n_errors, tests_run, cyc, npul} = '0;
    {resetn, pin, lng} = '0;
    diag = '0;
    diag.ch_sync_mode = 2'h3;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    x(0, A_GCR, 16'h0, 0);
    x(0, A_CHC, 16'h0, 0);
    chk("gcr reset", 16'h8000, r[15:0]);
    x(1, A_NOP, 16'hffff, 0);
    chk("chc reset", 16'h0442, r[15:0]);
    x(0, A_CHC, 16'h0, 0);
    chk("nop answer", 16'h0, r[15:0]);
    x(1, A_NOP, 16'h0, 0);
    chk("chc after nop", 16'h0442, r[15:0]);
    x(1, A_CHC, 16'h0443, 0);
    @(posedge clk);
    pin <= 2'h1;
    repeat (1100) @(posedge clk);
    pin <= 2'h0;
    $display("test reset done");
    x(1, A_GCR, 16'h0003, 0);
    repeat (1600) @(posedge clk);
    chk("parity fault", 16'h1, {15'h0, gf});
    x(1, A_GCR, 16'h4108, 0);
    chk("cfg", 16'h17, {11'h0, cfg.ch[0].trigger_source,
      cfg.addr_multiplex_off, cfg.ch[0].buffer_length_sel,
      cfg.ext_clk_1mhz});
    repeat (1600) @(posedge clk);
    chk("parity ok", 16'h0, {15'h0, gf});
    $display("test config done");
    x(1, A_GCR, 16'h0080, 0);
    x(1, A_CHC, 16'h0413, 0);
    chk("pulse", 16'h0101, {npul[7:0], 7'h0, lng});
    chk("on", 16'h1, {15'h0, cfg.ch[0].power_on});
    x(1, A_GCR, 16'h8280, 0);
    x(1, A_CHC, 16'h0413, 0);
    chk("buffer pulse", 16'h0200, {npul[7:0], 7'h0, lng});
    x(1, A_CHC, 16'h0012, 0);
    chk("off", 16'h0200, {npul[7:0], 7'h0, cfg.regulator_enable});
    $display("test sync done");
    x(1, A_DIRCMD, CMD_EOP, 0);
    x(1, A_GCR, 16'h0001, 0);
    chk("locked", 16'h1, {15'h0, lk});
    x(0, A_GCR, 16'h0, 0);
    x(1, A_NOP, 16'h0, 0);
    chk("gcr kept", 16'h8280, r[15:0]);
    $display("test lock done");
    @(posedge clk);
    diag.regulator_undervolt <= 1'b1;
    diag.coupling_test_done  <= 1'b1;
    diag.ch_buffer_pending   <= 2'h1;
    @(posedge clk);
    diag.regulator_undervolt <= 1'b0;
    diag.coupling_test_done  <= 1'b0;
    x(1, A_UDB_FIRST[0], 16'h0, 0);
    x(1, A_NOP, 16'h0, 1);
    x(0, A_SR1, 16'h0, 0);
    x(0, A_SR1, 16'h0, 0);
    chk("sr1 set", 16'h940c, r[15:0] & 16'h940c);
    x(1, A_NOP, 16'h0, 0);
    chk("sr1 clear", 16'h0, r[15:0] & 16'h940c);
    $display("test status done");
    summarize();
  end
endmodule

`default_nettype wire
